// *** bench/multi_timer_unit_checker.sv ***
/*
 checker: port-level assertions for multi_timer_unit.
 assumes: bound into every instance of the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module multi_timer_unit_checker
	import timer_ctl_pkg::*;
(
	// clock, reset and bus
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire bus_req_t    avs_req_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// pins and requests
	input wire logic [7:0]  timer_pin_i,
	input wire logic [7:0]  timer_pin_o,
	input wire logic [7:0]  timer_pin_oe_o,
	input wire logic [3:0]  irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// ---------------------------------
	// shadow of the last enable word
	// ---------------------------------
	logic [15:0] en_reg;
	logic [15:0] en_next;
	logic [3:0]  en_any;
	// only accepted full-word writes move the shadow
	always_comb
	begin
		en_next = en_reg;
		if (avs_req_i.write && !avs_waitrequest_o && avs_req_i.address == IDX_IRQ_EN
			&& (&avs_req_i.byteenable[1:0]))
			en_next = avs_req_i.writedata[15:0];
	end
	always_ff @(posedge clock_i)
		en_reg <= rst_b_i ? en_next : 16'h0000;
	assign en_any = {|en_reg[15:12], |en_reg[11:8], |en_reg[7:4], |en_reg[3:0]};
	// ---------------------------------
	// properties
	// ---------------------------------
	property p_wait_one;
		(avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after take");
	property p_wait_pulse;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low twice");
	property p_wait_idle;
		!(avs_req_i.read || avs_req_i.write) |=> avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
	property p_reset_vals;
		$rose(rst_b_i) |-> irq_o == 4'h0 && timer_pin_oe_o == 8'h00 && avs_readdata_o == 32'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("outputs not clear");
	property p_unmapped;
		avs_req_i.read && avs_waitrequest_o && avs_req_i.address == 5'h07 |=> avs_readdata_o == 0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_upper;
		avs_req_i.read && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_rd_hold;
		!(avs_req_i.read && avs_waitrequest_o) |=> $stable(avs_readdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_irq_gate;
		(irq_o & ~en_any) == 4'h0;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
endmodule
bind multi_timer_unit multi_timer_unit_checker chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .timer_pin_i(timer_pin_i),
	.timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o), .irq_o(irq_o));
`default_nettype wire

// *** bench/tb_multi_timer_unit.sv ***
/*
 tb_multi_timer_unit: register, prescaler, capture and pwm tests.
 assumes: timer_pin_model drives the pins, one access takes two cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_multi_timer_unit
	import timer_ctl_pkg::*;
;
	logic        clock;
	logic        rst_b;
	bus_req_t    req;
	logic [31:0] rdata;
	logic        wreq;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic [3:0]  irq;
	int          errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          i;
	int          j;
	int          n;
	logic [15:0] d0;
	logic [15:0] d1;
	logic [7:0]  ps [3] = '{8'h00, 8'h03, 8'hFF};
	// capture and counter-reset per edge code, bit k = code k
	localparam logic [7:0] CAP_R = 8'hF5;
	localparam logic [7:0] CAP_F = 8'hFA;
	localparam logic [7:0] CLR_R = 8'hA4;
	localparam logic [7:0] CLR_F = 8'hC8;
	multi_timer_unit dut (.clock_i(clock), .rst_b_i(rst_b), .avs_req_i(req),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .timer_pin_i(pin_in),
		.timer_pin_o(pin_out), .timer_pin_oe_o(pin_oe), .irq_o(irq));
	timer_pin_model pins (.pin_o_i(pin_out), .pin_oe_i(pin_oe), .pin_i_o(pin_in));
	// ---------------------------------
	// bus tasks and compare
	// ---------------------------------
	// the trailing edge keeps a new request out of the release time step
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q);
		req <= '{read: !w, write: w, address: a, writedata: {16'h0000, d}, byteenable: 4'hF};
		do @(posedge clock); while (wreq !== 1'b0);
		q = rdata[15:0];
		req <= '0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] q;
		acc(1'b0, a, 16'h0000, q);
		cmp(q, e);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// hang guard, far above the few thousand cycles the tests need
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			wrap_up();
		end
	end
	// ---------------------------------
	// tests
	// ---------------------------------
	initial
	begin
		rst_b = 1'b0;
		req = '0;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		for (i = 1; i < 12; i++) chk(i[4:0], 16'h0000);
		$display("reset values done");
		for (i = 1; i < 8; i++)
		begin
			if (i == 4) continue;
			wr(i[4:0], 16'hA5C3 ^ i[15:0]);
			chk(i[4:0], (i == 7) ? 16'h0000 : 16'hA5C3 ^ i[15:0]);
			wr(i[4:0], 16'h0000);
		end
		chk(IDX_IRQ_FLAGS, 16'h0000);
		$display("register access done");
		foreach (ps[k])
		begin
			wr(IDX_MODE, 16'h000C);
			wr(IDX_PRESC_A, {8'h00, ps[k]});
			wr(IDX_MODE, 16'h000D);
			acc(1'b0, IDX_COUNT0, 16'h0000, d0);
			repeat (8 * (ps[k] + 1) - 3) @(posedge clock);
			acc(1'b0, IDX_COUNT0, 16'h0000, d1);
			cmp(d1 - d0, 16'h0008);
		end
		wr(IDX_COUNT0, 16'h0000);
		chk(IDX_COUNT0, d1);
		wr(IDX_MODE, 16'h000C);
		acc(1'b0, IDX_COUNT0, 16'h0000, d0);
		repeat (600) @(posedge clock);
		chk(IDX_COUNT0, d0);
		wr(IDX_COUNT0, 16'h1234);
		chk(IDX_COUNT0, 16'h1234);
		$display("prescaler done");
		wr(IDX_PRESC_A, 16'h0000);
		wr(IDX_MODE, 16'h000D);
		for (i = 0; i < 8; i++)
		begin
			wr(IDX_PIN_LOW, i[15:0]);
			for (j = 1; j >= 0; j--)
			begin
				wr(IDX_IRQ_FLAGS, 16'h000F);
				repeat (200) @(posedge clock);
				pins.set_pin(0, j[0]);
				repeat (10) @(posedge clock);
				acc(1'b0, IDX_COUNT0, 16'h0000, d0);
				acc(1'b0, IDX_IRQ_FLAGS, 16'h0000, d1);
				cmp({15'h0, d1[0]}, {15'h0, j ? CAP_R[i] : CAP_F[i]});
				cmp({15'h0, d0 < 16'h0064}, {15'h0, j ? CLR_R[i] : CLR_F[i]});
			end
		end
		cmp({12'h000, irq}, 16'h0000);
		wr(IDX_IRQ_EN, 16'h0001);
		cmp({12'h000, irq}, 16'h0001);
		wr(IDX_MODE, 16'h0000);
		wr(IDX_IRQ_FLAGS, 16'h0001);
		chk(IDX_IRQ_FLAGS, 16'h0001);
		wr(IDX_MODE, 16'h000C);
		wr(IDX_IRQ_FLAGS, 16'hFFFE);
		chk(IDX_IRQ_FLAGS, 16'h0001);
		wr(IDX_IRQ_FLAGS, 16'h0001);
		chk(IDX_IRQ_FLAGS, 16'h0000);
		cmp({12'h000, irq}, 16'h0000);
		$display("capture and flags done");
		wr(IDX_MODE, 16'h0008);
		for (i = 0; i < 2; i++)
		begin
			wr(IDX_PIN_LOW, {12'h000, i[0], 3'b000});
			@(negedge clock);
			cmp({15'h0, pin_out[0]}, {15'h0, i[0]});
			@(posedge clock);
			wr(IDX_COUNT0, 16'h0000);
			wr(IDX_PERIOD0, 16'h0009);
			wr(IDX_DUTY0, 16'h0004);
			wr(IDX_MODE, 16'h0009);
			repeat (30) @(posedge clock);
			n = 0;
			repeat (10)
			begin
				@(negedge clock);
				n += (pin_out[0] === 1'b1);
			end
			@(posedge clock);
			cmp(n[15:0], i ? 16'h0007 : 16'h0003);
			cmp({8'h00, pin_oe}, 16'h0001);
			wr(IDX_MODE, 16'h0008);
		end
		// dual 8-bit: low byte period 10 duty 4, high byte period 5 duty 2, pin 2 inverted
		wr(IDX_COUNT0, 16'h0000);
		wr(IDX_PIN_LOW, 16'h0080);
		wr(IDX_PERIOD0, 16'h0409);
		wr(IDX_DUTY0, 16'h0204);
		wr(IDX_IRQ_FLAGS, 16'h000F);
		wr(IDX_MODE, 16'h0007);
		repeat (30) @(posedge clock);
		n = 0;
		j = 0;
		repeat (10)
		begin
			@(negedge clock);
			n += (pin_out[0] === 1'b1);
			j += (pin_out[1] === 1'b1);
		end
		@(posedge clock);
		cmp(n[15:0], 16'h0003);
		cmp(j[15:0], 16'h0008);
		cmp({8'h00, pin_oe}, 16'h0003);
		chk(IDX_IRQ_FLAGS, 16'h000F);
		wr(IDX_MODE, 16'h0004);
		@(negedge clock);
		cmp({14'h0000, pin_out[1:0]}, 16'h0002);
		@(posedge clock);
		$display("pwm done");
		wrap_up();
	end
endmodule
`default_nettype wire

// *** bench/timer_pin_model.sv ***
/*
 timer_pin_model: what stands on the eight timer pins.
 assumes: the bench sets input levels just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_pin_model (
	// design pin drive
	input  wire logic [7:0] pin_o_i,
	input  wire logic [7:0] pin_oe_i,
	// levels seen by the design
	output logic      [7:0] pin_i_o
);
	logic [7:0] lvl_reg = 8'h00;
	// a driven pin reads back the design level, the rest follow stimulus
	assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & lvl_reg);
	task automatic set_pin(input int k, input logic v);
		lvl_reg[k] <= v;
	endtask
endmodule
`default_nettype wire

// *** hdl/multi_timer_unit.sv ***
/*
 multi_timer_unit: control, status, prescalers and counters of a
 four-subsystem timer with pwm and capture on eight timer pins.
 assumes: one 20 MHz clock, synchronous active-low reset, an avalon-mm
 master that holds its request until waitrequest is seen low.
*/
// Behaviour
// - edge code picks capture edge and counter reset per pin
// - polarity 0: output high on 00h to 01h, low on duty match
// - polarity 1: output low on 00h to 01h, high on duty match
// - stopped counter forces its pwm output to the polarity bit
// - capture ignores polarity; pwm ignores edge code
// - first pin register: pins 1-4, nibble per pin, edge 2:0, polarity 3
// - second pin register: pins 5-8, same layout
// - enables gate only the request; flags set regardless
// - enable register changes only by software writes
// - flag set by event; write one clears, zero keeps
// - four flags a-d per subsystem, subsystem 1 in bits 3:0
// - reset clears all flags
// - prescaler divides by compare value plus one
// - prescaler pairs: low byte odd subsystem, high byte even
// - counter steps when prescaler count equals compare
// - counter reads give the live value at any time
// - reset clears pin, enable, prescaler and counter registers
// - flag a duty/capture-period, b period/capture-duty, c, d as mapped
// - each subsystem drives one interrupt request
// - in low power, writing one to its flags does not clear them
`timescale 1ns/10ps
`default_nettype none

module multi_timer_unit
	import timer_ctl_pkg::*;
(
	// clock and reset
	input  wire  logic        clock_i,
	input  wire  logic        rst_b_i,
	// register bus
	input  wire  bus_req_t    avs_req_i,
	output logic [31:0]       avs_readdata_o,
	output logic              avs_waitrequest_o,
	// timer pins
	input  wire  logic [7:0]  timer_pin_i,
	output logic [7:0]        timer_pin_o,
	output logic [7:0]        timer_pin_oe_o,
	// interrupt requests, one per subsystem
	output logic [3:0]        irq_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [15:0]       mode;
		logic [7:0][3:0]   pin_nib;
		logic [15:0]       irq_en;
		logic [15:0]       flags;
		logic [3:0][7:0]   presc;
		logic [3:0][7:0]   ps_cnt;
		logic [3:0][15:0]  cnt;
		logic [3:0][15:0]  per;
		logic [3:0][15:0]  dty;
		logic [7:0]        sync1;
		logic [7:0]        sync2;
		logic [7:0]        sync3;
		logic [7:0]        lvl;
		logic [7:0]        pin_out;
		logic [7:0]        pin_oe;
		logic [3:0]        irq;
		logic              wait_rq;
		logic [31:0]       rdata;
	} state_t;

	state_t r_reg;
	state_t r_next;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// edge code to {capture, counter reset}
	function automatic logic [1:0] edge_decode(input logic [2:0] code,
		input logic rise, input logic fall);
		logic cap;
		logic rst;
		// bit 2 selects both edges; below that, bit 0 selects the falling one
		cap = code[2] ? (rise | fall) : (code[0] ? fall : rise);
		rst = 1'b0;
		case (code)
			3'b010, 3'b101: rst = rise;
			3'b011, 3'b110: rst = fall;
			3'b111:         rst = rise | fall;
			default:        rst = 1'b0;
		endcase
		return {cap, rst};
	endfunction

	// one pwm counter step; period match wraps to zero, as does the top
	function automatic pwm_res_t pwm_step(input logic [15:0] cnt,
		input logic [15:0] per, input logic [15:0] dty,
		input logic [15:0] top);
		pwm_res_t res;
		res.pmatch = (cnt == per);
		if (res.pmatch || cnt == top)
			res.cnt = RST_WORD;
		else
			res.cnt = cnt + CNT_ONE;
		res.rise   = (res.cnt == CNT_ONE);
		res.dmatch = (res.cnt == dty);
		return res;
	endfunction

	// pin level after a pwm step for the given polarity
	function automatic logic pwm_level(input logic cur, input logic pol,
		input pwm_res_t res);
		logic lv;
		lv = cur;
		if (res.rise)
			lv = ~pol;
		if (res.dmatch)
			lv = pol;
		return lv;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// bus accesses need two cycles: waitrequest drops one edge after the
	// request appears, which keeps read data registered
	always_comb
	begin
		logic        req;
		logic        wr;
		logic        word_ok;
		logic [15:0] wd;
		logic [15:0] set;
		logic [15:0] clr;
		logic [7:0]  nlvl;
		logic [7:0]  rise;
		logic [7:0]  fall;
		tmode_t      md;
		logic        lp;
		logic        runl;
		logic        runh;
		logic        run_any;
		logic        tick;
		logic [1:0]  dl;
		logic [1:0]  dh;
		logic [3:0]  nl;
		logic [3:0]  nh;
		pwm_res_t    pl;
		pwm_res_t    ph;
		logic [15:0] hb;
		req     = avs_req_i.read | avs_req_i.write;
		wr      = avs_req_i.write & ~r_reg.wait_rq;
		word_ok = (avs_req_i.byteenable[1:0] == 2'b11);
		wd      = avs_req_i.writedata[15:0];
		set     = '0;
		clr     = '0;
		md      = MODE_LOW_POWER;
		lp      = 1'b0;
		runl    = 1'b0;
		runh    = 1'b0;
		run_any = 1'b0;
		tick    = 1'b0;
		dl      = '0;
		dh      = '0;
		nl      = '0;
		nh      = '0;
		pl      = '0;
		ph      = '0;
		hb      = '0;
		r_next  = r_reg;

		// pin inputs: three stages, a level counts once stages 2 and 3 agree
		r_next.sync1 = timer_pin_i;
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		nlvl = (r_reg.sync2 & r_reg.sync3) | (r_reg.lvl & (r_reg.sync2 ^ r_reg.sync3));
		r_next.lvl = nlvl;
		rise = nlvl & ~r_reg.lvl;
		fall = ~nlvl & r_reg.lvl;

		// software writes to the plain control registers
		if (wr && word_ok)
		begin
			unique case (avs_req_i.address)
				IDX_MODE:     r_next.mode = wd;
				IDX_PIN_LOW:  r_next.pin_nib[3:0] = wd;
				IDX_PIN_HIGH: r_next.pin_nib[7:4] = wd;
				IDX_IRQ_EN:   r_next.irq_en = wd;
				IDX_IRQ_FLAGS: clr = wd;
				IDX_PRESC_A:  r_next.presc[1:0] = wd;
				IDX_PRESC_B:  r_next.presc[3:2] = wd;
				default: ;
			endcase
		end

		// per subsystem: prescaler, counter, pins and events
		for (int s = 0; s < 4; s++)
		begin
			md   = tmode_t'(r_reg.mode[4*s+2 +: 2]);
			lp   = (md == MODE_LOW_POWER);
			runl = r_reg.mode[4*s] & ~lp;
			runh = r_reg.mode[4*s+1] & ~lp;
			run_any = (md == MODE_DUAL8) ? (runl | runh) : runl;
			tick = run_any && (r_reg.ps_cnt[s] == r_reg.presc[s]);
			if (run_any)
				r_next.ps_cnt[s] = tick ? 8'h00 : r_reg.ps_cnt[s] + 8'h01;
			nl = r_reg.pin_nib[2*s];
			nh = r_reg.pin_nib[2*s+1];
			hb = {8'h00, r_reg.cnt[s][15:8]};
			r_next.pin_oe[2*s]   = (md == MODE_DUAL8) || (md == MODE_PWM16);
			r_next.pin_oe[2*s+1] = (md == MODE_DUAL8);

			unique case (md)
				MODE_PWM16:
				begin
					// higher pin is not driven in 16-bit pwm
					pl = pwm_step(r_reg.cnt[s], r_reg.per[s], r_reg.dty[s], CNT_TOP16);
					r_next.pin_out[2*s+1] = nh[3];
					if (!runl)
						r_next.pin_out[2*s] = nl[3];
					else if (tick)
					begin
						r_next.cnt[s] = pl.cnt;
						r_next.pin_out[2*s] = pwm_level(r_reg.pin_out[2*s], nl[3], pl);
						set[4*s]   = pl.dmatch;
						set[4*s+1] = pl.pmatch;
					end
				end
				MODE_DUAL8:
				begin
					pl = pwm_step({8'h00, r_reg.cnt[s][7:0]}, {8'h00, r_reg.per[s][7:0]},
						{8'h00, r_reg.dty[s][7:0]}, CNT_TOP8);
					ph = pwm_step(hb, {8'h00, r_reg.per[s][15:8]},
						{8'h00, r_reg.dty[s][15:8]}, CNT_TOP8);
					if (!runl)
						r_next.pin_out[2*s] = nl[3];
					else if (tick)
					begin
						r_next.cnt[s][7:0] = pl.cnt[7:0];
						r_next.pin_out[2*s] = pwm_level(r_reg.pin_out[2*s], nl[3], pl);
						set[4*s]   = pl.dmatch;
						set[4*s+1] = pl.pmatch;
					end
					if (!runh)
						r_next.pin_out[2*s+1] = nh[3];
					else if (tick)
					begin
						r_next.cnt[s][15:8] = ph.cnt[7:0];
						r_next.pin_out[2*s+1] = pwm_level(r_reg.pin_out[2*s+1], nh[3], ph);
						set[4*s+2] = ph.dmatch;
						set[4*s+3] = ph.pmatch;
					end
				end
				MODE_CAPTURE:
				begin
					// pins are inputs; the polarity bit plays no part here
					r_next.pin_out[2*s]   = 1'b0;
					r_next.pin_out[2*s+1] = 1'b0;
					if (runl)
					begin
						if (tick)
						begin
							r_next.cnt[s] = r_reg.cnt[s] + CNT_ONE;
							set[4*s+2] = (r_reg.cnt[s] == CNT_TOP16);
						end
						dl = edge_decode(nl[2:0], rise[2*s], fall[2*s]);
						dh = edge_decode(nh[2:0], rise[2*s+1], fall[2*s+1]);
						if (dl[1])
							r_next.per[s] = r_reg.cnt[s];
						if (dh[1])
							r_next.dty[s] = r_reg.cnt[s];
						set[4*s]   = set[4*s] | dl[1];
						set[4*s+1] = set[4*s+1] | dh[1];
						if (dl[0] || dh[0])
						begin
							r_next.cnt[s]    = RST_WORD;
							r_next.ps_cnt[s] = 8'h00;
						end
					end
				end
				MODE_LOW_POWER:
				begin
					// everything frozen; outputs rest at the polarity level
					r_next.pin_out[2*s]   = nl[3];
					r_next.pin_out[2*s+1] = nh[3];
					clr[4*s +: 4] = 4'h0;
				end
			endcase

			// counter, period and duty writes; counter only while stopped
			if (wr && word_ok && !lp)
			begin
				if (avs_req_i.address == IDX_COUNT0 + 5'(s) && !runl && !runh)
					r_next.cnt[s] = wd;
				if (avs_req_i.address == IDX_PERIOD0 + 5'(s))
					r_next.per[s] = wd;
				if (avs_req_i.address == IDX_DUTY0 + 5'(s))
					r_next.dty[s] = wd;
			end
		end

		// flags: a hardware event wins over a clearing write
		r_next.flags = (r_reg.flags & ~clr) | set;
		for (int s = 0; s < 4; s++)
			r_next.irq[s] = |(r_next.flags[4*s +: 4] & r_next.irq_en[4*s +: 4]);

		// bus handshake and read data
		r_next.wait_rq = ~(req & r_reg.wait_rq);
		if (avs_req_i.read && r_reg.wait_rq)
		begin
			r_next.rdata = '0;
			unique case (avs_req_i.address)
				IDX_MODE:      r_next.rdata[15:0] = r_reg.mode;
				IDX_PIN_LOW:   r_next.rdata[15:0] = r_reg.pin_nib[3:0];
				IDX_PIN_HIGH:  r_next.rdata[15:0] = r_reg.pin_nib[7:4];
				IDX_IRQ_EN:    r_next.rdata[15:0] = r_reg.irq_en;
				IDX_IRQ_FLAGS: r_next.rdata[15:0] = r_reg.flags;
				IDX_PRESC_A:   r_next.rdata[15:0] = r_reg.presc[1:0];
				IDX_PRESC_B:   r_next.rdata[15:0] = r_reg.presc[3:2];
				default:
				begin
					for (int s = 0; s < 4; s++)
					begin
						if (avs_req_i.address == IDX_COUNT0 + 5'(s))
							r_next.rdata[15:0] = r_reg.cnt[s];
						if (avs_req_i.address == IDX_PERIOD0 + 5'(s))
							r_next.rdata[15:0] = r_reg.per[s];
						if (avs_req_i.address == IDX_DUTY0 + 5'(s))
							r_next.rdata[15:0] = r_reg.dty[s];
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// all state clears on reset; waitrequest idles high
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			r_reg         <= '0;
			r_reg.wait_rq <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	// ----------------------------------------
	// outputs, straight from the state
	// ----------------------------------------
	assign avs_readdata_o    = r_reg.rdata;
	assign avs_waitrequest_o = r_reg.wait_rq;
	assign timer_pin_o       = r_reg.pin_out;
	assign timer_pin_oe_o    = r_reg.pin_oe;
	assign irq_o             = r_reg.irq;

endmodule

`default_nettype wire

// *** hdl/timer_ctl_pkg.sv ***
/*
 timer_ctl_pkg: offsets, reset values and carrier types of the timer unit.
 assumes: word-addressed avalon slave, 32-bit data, registers in low 16 bits.
*/
package timer_ctl_pkg;

	// ----------------------------------------
	// word indices of the registers
	// ----------------------------------------
	localparam logic [4:0] IDX_MODE      = 5'h00;
	localparam logic [4:0] IDX_PIN_LOW   = 5'h01;
	localparam logic [4:0] IDX_PIN_HIGH  = 5'h02;
	localparam logic [4:0] IDX_IRQ_EN    = 5'h03;
	localparam logic [4:0] IDX_IRQ_FLAGS = 5'h04;
	localparam logic [4:0] IDX_PRESC_A   = 5'h05;
	localparam logic [4:0] IDX_PRESC_B   = 5'h06;
	localparam logic [4:0] IDX_COUNT0    = 5'h08;
	localparam logic [4:0] IDX_PERIOD0   = 5'h0C;
	localparam logic [4:0] IDX_DUTY0     = 5'h10;

	// ----------------------------------------
	// values after reset and fixed figures
	// ----------------------------------------
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [15:0] CNT_TOP16 = 16'hFFFF;
	localparam logic [15:0] CNT_TOP8  = 16'h00FF;
	localparam logic [15:0] CNT_ONE   = 16'h0001;

	// ----------------------------------------
	// subsystem operating modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_LOW_POWER = 2'b00,
		MODE_DUAL8     = 2'b01,
		MODE_PWM16     = 2'b10,
		MODE_CAPTURE   = 2'b11
	} tmode_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} bus_req_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic        rise;
		logic        dmatch;
		logic        pmatch;
	} pwm_res_t;

endpackage
